// [rtl/uth_pkg.sv]
package uth_pkg;
    // register indices (word offsets on the documented port)
    localparam logic [2:0] IDX_RXDATA = 3'h0;
    localparam logic [2:0] IDX_TXDATA = 3'h1;
    localparam logic [2:0] IDX_STATUS = 3'h2;
    localparam logic [2:0] IDX_CONTROL = 3'h3;
    localparam int REG_W = 16;
    // line_flags bit positions
    localparam int ST_PARITY_FAULT = 0;
    localparam int ST_STOP_BIT_FAULT = 1;
    localparam int ST_BRK = 2;
    localparam int ST_ROE = 3;
    localparam int ST_TOE = 4;
    localparam int ST_TMT = 5;
    localparam int ST_TRDY = 6;
    localparam int ST_RRDY = 7;
    localparam int ST_E = 8;
    localparam int ST_DCTS = 10;
    localparam int ST_CTS = 11;
    // control bits beyond the interrupt enables
    localparam int CT_TRBK = 9;
    localparam int CT_RTS = 11;
    localparam logic [15:0] CTRL_MASK = 16'h1fff;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] ZERO16 = 16'h0000;
    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int BAUD_DEF = 115_200;
    localparam logic [2:0] SYNC_IDLE = 3'h7;

    typedef enum logic {
        TX_IDLE = 1'b0,
        TX_BUSY = 1'b1
    } uth_tx_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } uth_rx_t;
endpackage

// [rtl/uth_top.sv]
// Behaviour
// - writing the transmit holding register drops transmit-ready to 0
// - moving the held character into the shifter raises transmit-ready
// - a second character waits, transmit-ready low, until the shifter frees
// - reading the transmit holding register returns an undefined value
// - reading the flag register never changes any flag
// - a flag register write clears change, summary, overrun, break, framing, parity
// - wrong received parity sets sticky parity_fault, bit 0
// - without the parity option no checking and parity_fault reads 0
// - missing stop bit sets sticky stop_bit_fault, bit 1
// - receive data may be undefined while a fault flag is set
// - input low longer than one character time sets sticky break, bit 2
// - character arriving while the receive fifo is full overwrites and sets receive overrun, bit 3
// - holding write while transmit-ready 0 sets sticky transmit overrun, bit 4
// - bit 5 is 0 while shifting, 1 while the shifter is idle
// - bit 6 is 1 with holding register empty, 0 when full
// - bit 7 sets on receive load, clears on receive data read
// - bit 8 is the OR of the five fault flags
// - bit 10 latches any clear-to-send change; 0 without flow control
// - bit 11 shows clear-to-send level; 0 without flow control
// - clear-to-send never affects transmit or receive
// - interrupt request when any flag and its enable are both 1; bit 11 has no enable, as control bit 11 is the rts line control
`timescale 1ns/1ps
`default_nettype none

module uth_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW:0] EMPTY = '0;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } uth_fifo_state_t;

    uth_fifo_state_t s_q, s_d;
    logic push, pop;

    assign in_ready = (s_q.cnt != FULL);
    assign out_valid = (s_q.cnt != EMPTY);
    assign out_data = s_q.mem[s_q.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp = s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = s_q.rp + 1'b1;
        end
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

module uth_top #(
    parameter int DATA_BITS = 8,
    parameter int PARITY_EN = 1,
    parameter int ODD_PARITY = 0,
    parameter int STOP_BITS = 1,
    parameter int FLOW_EN = 1,
    parameter int BAUD = uth_pkg::BAUD_DEF,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [2:0] address,
    input wire logic chipselect,
    input wire logic read,
    input wire logic write,
    input wire logic [15:0] writedata,
    output logic [15:0] readdata,
    output logic irq,
    input wire logic rxd,
    output logic txd,
    input wire logic cts_n,
    output logic rts_n
);
    localparam int BAUD_DIV = uth_pkg::CLK_HZ / BAUD;
    localparam int DW = $clog2(BAUD_DIV + 1);
    localparam int FW = 1 + DATA_BITS + PARITY_EN + STOP_BITS;
    localparam int LW = $clog2(FW + 1);
    localparam int CHAR_CYC = FW * BAUD_DIV;
    localparam int BW = $clog2(CHAR_CYC + 2);
    localparam logic [DW-1:0] DIV_LAST = DW'(BAUD_DIV - 1);
    localparam logic [DW-1:0] HALF_LAST = DW'(BAUD_DIV / 2 - 1);
    localparam logic [LW-1:0] FRAME_LEN = LW'(FW);
    localparam logic [LW-1:0] LAST_BIT = LW'(1);
    localparam logic [3:0] RX_BITS_LAST = 4'(DATA_BITS + PARITY_EN - 1);
    localparam logic [BW-1:0] BRK_CYC = BW'(CHAR_CYC);

    typedef struct packed {
        logic [2:0] rx_s;
        logic rx_lvl;
        logic [2:0] cts_s;
        logic cts_lvl;
        logic [15:0] ctrl;
        logic [15:0] rdata;
        logic [DATA_BITS-1:0] hold;
        logic hold_v;
        uth_pkg::uth_tx_t tx_st;
        logic [FW-1:0] tx_sh;
        logic [LW-1:0] tx_left;
        logic [DW-1:0] tx_div;
        logic txd;
        uth_pkg::uth_rx_t rx_st;
        logic [DW-1:0] rx_div;
        logic [3:0] rx_cnt;
        logic [DATA_BITS-1:0] rx_sh;
        logic rx_par;
        logic [BW-1:0] brk_cnt;
        logic [DATA_BITS-1:0] rxdata;
        logic rrdy, parity_fault, stop_bit_fault, brk, roe, toe, dcts;
    } uth_state_t;

    uth_state_t s_q, s_d;
    logic [15:0] stat, irq_en;
    logic err, rx_done, ovf, pop, f_in_ready, f_out_valid;
    logic wr_tx, wr_st, wr_ct, rd_rx, rd_st;
    logic [DATA_BITS-1:0] f_out_data;

    function automatic logic par_of(input logic [DATA_BITS-1:0] d);
        par_of = (^d) ^ (ODD_PARITY != 0);
    endfunction

    function automatic logic hit(input logic [2:0] a, input logic [2:0] idx);
        hit = chipselect && (a == idx);
    endfunction

    assign wr_tx = write && hit(address, uth_pkg::IDX_TXDATA);
    assign wr_st = write && hit(address, uth_pkg::IDX_STATUS);
    assign wr_ct = write && hit(address, uth_pkg::IDX_CONTROL);
    assign rd_rx = read && hit(address, uth_pkg::IDX_RXDATA);
    assign rd_st = read && hit(address, uth_pkg::IDX_STATUS);

    assign err = s_q.toe | s_q.roe | s_q.brk | s_q.stop_bit_fault | s_q.parity_fault;

    always_comb begin
        stat = uth_pkg::ZERO16;
        irq_en = s_q.ctrl;
        irq_en[uth_pkg::CT_TRBK] = 1'b0;
        irq_en[uth_pkg::CT_RTS] = 1'b0; // line controls, not interrupt enables
        stat[uth_pkg::ST_PARITY_FAULT] = s_q.parity_fault;
        stat[uth_pkg::ST_STOP_BIT_FAULT] = s_q.stop_bit_fault;
        stat[uth_pkg::ST_BRK] = s_q.brk;
        stat[uth_pkg::ST_ROE] = s_q.roe;
        stat[uth_pkg::ST_TOE] = s_q.toe;
        stat[uth_pkg::ST_TMT] = (s_q.tx_st == uth_pkg::TX_IDLE);
        stat[uth_pkg::ST_TRDY] = !s_q.hold_v;
        stat[uth_pkg::ST_RRDY] = s_q.rrdy;
        stat[uth_pkg::ST_E] = err;
        stat[uth_pkg::ST_DCTS] = s_q.dcts;
        stat[uth_pkg::ST_CTS] = (FLOW_EN != 0) && !s_q.cts_lvl;
    end

    assign irq = |(stat & irq_en);
    assign readdata = s_q.rdata;
    assign txd = s_q.txd;
    assign rts_n = !s_q.ctrl[uth_pkg::CT_RTS];

    // receive path buffer; full fifo forces the overwrite path
    assign rx_done = (s_q.rx_st == uth_pkg::RX_STOP) && (s_q.rx_div == DIV_LAST);
    assign ovf = rx_done && !f_in_ready;
    assign pop = f_out_valid && !s_q.rrdy && !ovf;

    uth_fifo #(.WIDTH(DATA_BITS), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk(clk),
        .srst(srst),
        .in_valid(rx_done),
        .in_ready(f_in_ready),
        .in_data(s_q.rx_sh),
        .out_valid(f_out_valid),
        .out_ready(!s_q.rrdy && !ovf),
        .out_data(f_out_data)
    );

    always_comb begin
        s_d = s_q;
        // three-stage pin sync, change taken when stages two and three agree
        s_d.rx_s = {s_q.rx_s[1:0], rxd};
        s_d.cts_s = {s_q.cts_s[1:0], cts_n};
        if (s_q.rx_s[1] == s_q.rx_s[2]) begin
            s_d.rx_lvl = s_q.rx_s[2];
        end
        if (s_q.cts_s[1] == s_q.cts_s[2]) begin
            s_d.cts_lvl = s_q.cts_s[2];
        end
        // clears first so that a same-cycle set wins
        if (wr_st) begin
            s_d.dcts = 1'b0;
            s_d.toe = 1'b0;
            s_d.roe = 1'b0;
            s_d.brk = 1'b0;
            s_d.stop_bit_fault = 1'b0;
            s_d.parity_fault = 1'b0;
        end
        if (rd_rx) begin
            s_d.rrdy = 1'b0;
        end
        if (wr_ct) begin
            s_d.ctrl = writedata & uth_pkg::CTRL_MASK;
        end
        if (FLOW_EN != 0 && s_d.cts_lvl != s_q.cts_lvl) begin
            s_d.dcts = 1'b1;
        end
        // register read data; only a receive data read changes a flag, clearing receive-ready
        if (chipselect && read) begin
            unique case (address)
                uth_pkg::IDX_RXDATA: s_d.rdata = 16'(s_q.rxdata);
                uth_pkg::IDX_STATUS: s_d.rdata = stat;
                uth_pkg::IDX_CONTROL: s_d.rdata = s_q.ctrl;
                default: s_d.rdata = uth_pkg::ZERO16;
            endcase
        end
        // transmit side
        unique case (s_q.tx_st)
            uth_pkg::TX_IDLE: begin
                if (s_q.hold_v) begin
                    s_d.tx_sh = '1;
                    s_d.tx_sh[0] = 1'b0;
                    s_d.tx_sh[DATA_BITS:1] = s_q.hold;
                    if (PARITY_EN != 0) begin
                        s_d.tx_sh[DATA_BITS+1] = par_of(s_q.hold);
                    end
                    s_d.tx_left = FRAME_LEN;
                    s_d.tx_div = '0;
                    s_d.hold_v = 1'b0;
                    s_d.tx_st = uth_pkg::TX_BUSY;
                end
            end
            uth_pkg::TX_BUSY: begin
                if (s_q.tx_div == DIV_LAST) begin
                    s_d.tx_div = '0;
                    s_d.tx_sh = {1'b1, s_q.tx_sh[FW-1:1]};
                    s_d.tx_left = s_q.tx_left - 1'b1;
                    if (s_q.tx_left == LAST_BIT) begin
                        s_d.tx_st = uth_pkg::TX_IDLE;
                    end
                end else begin
                    s_d.tx_div = s_q.tx_div + 1'b1;
                end
            end
        endcase
        if (wr_tx) begin
            if (s_q.hold_v) begin
                s_d.toe = 1'b1;
            end
            s_d.hold = writedata[DATA_BITS-1:0];
            s_d.hold_v = 1'b1;
        end
        s_d.txd = (s_d.tx_st == uth_pkg::TX_BUSY ? s_d.tx_sh[0] : 1'b1)
                  && !s_d.ctrl[uth_pkg::CT_TRBK];
        // receive side
        unique case (s_q.rx_st)
            uth_pkg::RX_IDLE: begin
                s_d.rx_div = '0;
                if (!s_q.rx_lvl) begin
                    s_d.rx_st = uth_pkg::RX_START;
                end
            end
            uth_pkg::RX_START: begin
                s_d.rx_div = s_q.rx_div + 1'b1;
                if (s_q.rx_div == HALF_LAST) begin
                    s_d.rx_div = '0;
                    s_d.rx_cnt = '0;
                    s_d.rx_st = s_q.rx_lvl ? uth_pkg::RX_IDLE : uth_pkg::RX_DATA;
                end
            end
            uth_pkg::RX_DATA: begin
                s_d.rx_div = s_q.rx_div + 1'b1;
                if (s_q.rx_div == DIV_LAST) begin
                    s_d.rx_div = '0;
                    s_d.rx_cnt = s_q.rx_cnt + 1'b1;
                    if (s_q.rx_cnt < 4'(DATA_BITS)) begin
                        s_d.rx_sh = {s_q.rx_lvl, s_q.rx_sh[DATA_BITS-1:1]};
                    end else begin
                        s_d.rx_par = s_q.rx_lvl;
                    end
                    if (s_q.rx_cnt == RX_BITS_LAST) begin
                        s_d.rx_st = uth_pkg::RX_STOP;
                    end
                end
            end
            uth_pkg::RX_STOP: begin
                s_d.rx_div = s_q.rx_div + 1'b1;
                if (rx_done) begin
                    s_d.rx_st = uth_pkg::RX_IDLE;
                    if (!s_q.rx_lvl) begin
                        s_d.stop_bit_fault = 1'b1;
                    end
                    if (PARITY_EN != 0 && s_q.rx_par != par_of(s_q.rx_sh)) begin
                        s_d.parity_fault = 1'b1;
                    end
                end
            end
        endcase
        if (ovf) begin
            s_d.rxdata = s_q.rx_sh;
            s_d.rrdy = 1'b1;
            s_d.roe = 1'b1;
        end else if (pop) begin
            s_d.rxdata = f_out_data;
            s_d.rrdy = 1'b1;
        end
        // break: line low longer than one full character
        if (s_q.rx_lvl) begin
            s_d.brk_cnt = '0;
        end else if (s_q.brk_cnt <= BRK_CYC) begin
            s_d.brk_cnt = s_q.brk_cnt + 1'b1;
            if (s_q.brk_cnt == BRK_CYC) begin
                s_d.brk = 1'b1;
            end
        end
        if (PARITY_EN == 0) begin
            s_d.parity_fault = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
            s_q.rx_s <= uth_pkg::SYNC_IDLE;
            s_q.rx_lvl <= 1'b1;
            s_q.cts_s <= uth_pkg::SYNC_IDLE;
            s_q.cts_lvl <= 1'b1;
            s_q.ctrl <= uth_pkg::CTRL_RST;
            s_q.tx_st <= uth_pkg::TX_IDLE;
            s_q.rx_st <= uth_pkg::RX_IDLE;
            s_q.txd <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    tx_write_busy_a: assert property (wr_tx |=> !stat[uth_pkg::ST_TRDY])
        else $error("transmit-ready not low after holding write");
    tx_load_ready_a: assert property ((s_q.tx_st == uth_pkg::TX_IDLE) && s_q.hold_v
        && !wr_tx |=> stat[uth_pkg::ST_TRDY] && !stat[uth_pkg::ST_TMT])
        else $error("load into shifter did not raise transmit-ready");
    tx_hold_wait_a: assert property ((s_q.tx_st == uth_pkg::TX_BUSY) && s_q.hold_v
        && !(s_q.tx_div == DIV_LAST && s_q.tx_left == LAST_BIT) |=> s_q.hold_v)
        else $error("held character left before shifter freed");
    tx_overrun_a: assert property (wr_tx && s_q.hold_v |=> s_q.toe)
        else $error("transmit overrun not flagged");
    flag_clear_a: assert property ($fell(s_q.parity_fault) || $fell(s_q.stop_bit_fault)
        || $fell(s_q.brk) || $fell(s_q.roe) || $fell(s_q.toe) |-> $past(wr_st))
        else $error("fault flag cleared without a flag write");
    summary_or_a: assert property (rd_st |=> readdata[uth_pkg::ST_E] == |readdata[4:0])
        else $error("summary flag differs from fault OR");
    rx_read_clear_a: assert property (rd_rx && !pop && !ovf |=> !s_q.rrdy)
        else $error("receive-ready survived receive data read");
    rx_overrun_a: assert property (ovf |=> s_q.roe && s_q.rrdy)
        else $error("receive overrun not flagged");
    cts_change_a: assert property ((FLOW_EN != 0) && $changed(s_q.cts_lvl)
        |-> s_q.dcts)
        else $error("clear-to-send change not latched");
    break_set_a: assert property (!s_q.rx_lvl && s_q.brk_cnt == BRK_CYC |=> s_q.brk)
        else $error("break not flagged after a character time low");
    no_parity_a: assert property ((PARITY_EN == 0) |-> !s_q.parity_fault)
        else $error("parity fault set without parity option");
    tmt_start_a: assert property ($fell(stat[uth_pkg::ST_TMT]) |-> $past(s_q.hold_v)
        && !txd)
        else $error("shifter busy without a held character");
endmodule

`default_nettype wire

// [sim/uth_line_model.sv]
`timescale 1ns/1ps
`default_nettype none

module uth_line_model #(
    parameter int BIT_CYC = 10
) (
    input wire logic clk,
    input wire logic txd,
    output logic rxd,
    output logic [7:0] last_char,
    output logic [15:0] got_cnt,
    output logic frame_bad
);
    logic [7:0] sh;
    initial begin
        rxd = 1'b1;
        last_char = 8'h00;
        got_cnt = 16'h0000;
        frame_bad = 1'b0;
    end
    // decode frames on txd, sampled mid bit, even parity
    always begin
        @(negedge txd);
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            sh[i] = txd;
        end
        repeat (BIT_CYC) @(posedge clk);
        if (txd !== ^sh) frame_bad = 1'b1;
        repeat (BIT_CYC) @(posedge clk);
        if (txd !== 1'b1) frame_bad = 1'b1;
        last_char = sh;
        got_cnt = got_cnt + 16'h0001;
    end
    // line idles high; frame can carry a wrong parity or stop bit on request
    task automatic send_char(input logic [7:0] d, input logic bad_par, input logic bad_stop);
        logic [10:0] fr;
        fr = {~bad_stop, (^d) ^ bad_par, d, 1'b0};
        for (int k = 0; k < 11; k++) begin
            @(negedge clk);
            rxd = fr[k];
            repeat (BIT_CYC - 1) @(negedge clk);
        end
        @(negedge clk);
        rxd = 1'b1;
    endtask
    task automatic hold_low(input int n);
        @(negedge clk);
        rxd = 1'b0;
        repeat (n) @(negedge clk);
        rxd = 1'b1;
    endtask
endmodule

`default_nettype wire

// [sim/uth_top_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module uth_top_tb_top;
    localparam int BIT_CYC = 10;
    logic clk, srst, chipselect, read, write, rxd, txd, cts_n, rts_n, irq, frame_bad;
    logic [2:0] address;
    logic [15:0] writedata, readdata, rd, got_cnt;
    logic [7:0] last_char;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;

    uth_top #(.BAUD(2_000_000)) i_dut (.clk(clk), .srst(srst), .address(address),
        .chipselect(chipselect), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .irq(irq), .rxd(rxd), .txd(txd), .cts_n(cts_n), .rts_n(rts_n));
    uth_line_model #(.BIT_CYC(BIT_CYC)) i_line (.clk(clk), .txd(txd), .rxd(rxd),
        .last_char(last_char), .got_cnt(got_cnt), .frame_bad(frame_bad));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            $display("MISMATCH at %0t: run too long", $time);
            report_and_stop();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic bus_wr(input logic [2:0] a, input logic [15:0] d);
        @(negedge clk);
        chipselect = 1'b1;
        write = 1'b1;
        address = a;
        writedata = d;
        @(negedge clk);
        chipselect = 1'b0;
        write = 1'b0;
    endtask
    task automatic bus_rd(input logic [2:0] a, output logic [15:0] d);
        @(negedge clk);
        chipselect = 1'b1;
        read = 1'b1;
        address = a;
        @(negedge clk);
        chipselect = 1'b0;
        read = 1'b0;
        @(negedge clk);
        d = readdata;
    endtask
    task automatic flags(input logic [15:0] exp, input string what);
        bus_rd(uth_pkg::IDX_STATUS, rd);
        check(rd, exp, what);
    endtask
    // poll bit b of the flags until it reads v
    task automatic poll_flag(input int b, input logic v);
        for (int k = 0; k < 2500; k++) begin
            bus_rd(uth_pkg::IDX_STATUS, rd);
            if (rd[b] === v) return;
        end
        check(16'h0000, 16'h0001, "flag poll");
    endtask
    task automatic wait_tx(input logic [15:0] n);
        for (int k = 0; k < 400 && got_cnt !== n; k++) @(negedge clk);
        check(got_cnt, n, "frames seen");
    endtask
    // empty receive path, then clear sticky flags
    task automatic drain();
        for (int k = 0; k < 20; k++) begin
            bus_rd(uth_pkg::IDX_STATUS, rd);
            if (rd[uth_pkg::ST_RRDY] === 1'b0) break;
            bus_rd(uth_pkg::IDX_RXDATA, rd);
        end
        bus_wr(uth_pkg::IDX_STATUS, 16'h0000);
        flags(16'h0060, "after drain");
    endtask

    initial begin
        srst = 1'b1;
        chipselect = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 3'h0;
        writedata = 16'h0000;
        cts_n = 1'b1;
        repeat (20) @(negedge clk);
        srst = 1'b0;
        flags(16'h0060, "reset flags");
        $display("test reset done");

        bus_wr(uth_pkg::IDX_TXDATA, 16'h00a5);
        repeat (5) @(negedge clk);
        bus_wr(uth_pkg::IDX_TXDATA, 16'h005a);
        flags(16'h0000, "two chars held");
        wait_tx(16'h0001);
        check({8'h00, last_char}, 16'h00a5, "first char");
        repeat (BIT_CYC + 2) @(negedge clk);
        flags(16'h0040, "second moved");
        wait_tx(16'h0002);
        check({8'h00, last_char}, 16'h005a, "second char");
        poll_flag(uth_pkg::ST_TMT, 1'b1);
        check({15'h0000, frame_bad}, 16'h0000, "frame shape");
        $display("test transmit done");

        bus_wr(uth_pkg::IDX_CONTROL, 16'h0010);
        bus_wr(3'h6, 16'hffff);
        bus_wr(uth_pkg::IDX_RXDATA, 16'h00ff);
        bus_rd(uth_pkg::IDX_CONTROL, rd);
        check(rd, 16'h0010, "control kept");
        bus_rd(3'h6, rd);
        check(rd, 16'h0000, "unmapped read");
        bus_wr(uth_pkg::IDX_TXDATA, 16'h0011);
        repeat (5) @(negedge clk);
        bus_wr(uth_pkg::IDX_TXDATA, 16'h0022);
        bus_wr(uth_pkg::IDX_TXDATA, 16'h0033);
        flags(16'h0110, "transmit overrun");
        flags(16'h0110, "read leaves flags");
        check({15'h0000, irq}, 16'h0001, "irq on");
        bus_wr(uth_pkg::IDX_STATUS, 16'h0000);
        flags(16'h0000, "overrun cleared");
        check({15'h0000, irq}, 16'h0000, "irq off");
        bus_wr(uth_pkg::IDX_CONTROL, 16'h0000);
        wait_tx(16'h0004);
        poll_flag(uth_pkg::ST_TMT, 1'b1);
        $display("test overrun done");

        i_line.send_char(8'h3c, 1'b0, 1'b0);
        poll_flag(uth_pkg::ST_RRDY, 1'b1);
        flags(16'h00e0, "rx ready");
        bus_rd(uth_pkg::IDX_RXDATA, rd);
        check(rd, 16'h003c, "rx char");
        flags(16'h0060, "rx consumed");
        for (int c = 0; c < 2; c++) begin
            i_line.send_char(8'h3c, c == 0, c == 1);
            poll_flag(uth_pkg::ST_RRDY, 1'b1);
            flags(c == 0 ? 16'h01e1 : 16'h01e2, "line fault");
            drain();
        end
        $display("test receive done");

        i_line.hold_low(200);
        repeat (3 * 11 * BIT_CYC) @(negedge clk);
        bus_rd(uth_pkg::IDX_STATUS, rd);
        check({14'h0000, rd[uth_pkg::ST_E], rd[uth_pkg::ST_BRK]}, 16'h0003, "break");
        drain();
        for (int n = 0; n < 18; n++) i_line.send_char(8'(n), 1'b0, 1'b0);
        repeat (20) @(negedge clk);
        flags(16'h01e8, "rx overrun");
        drain();
        $display("test break and overrun done");

        @(negedge clk);
        cts_n = 1'b0;
        repeat (8) @(negedge clk);
        flags(16'h0c60, "cts asserted");
        bus_wr(uth_pkg::IDX_STATUS, 16'h0000);
        flags(16'h0860, "change cleared");
        bus_wr(uth_pkg::IDX_CONTROL, 16'h0a00);
        check({13'h0000, irq, rts_n, txd}, 16'h0000, "rts and line break");
        bus_wr(uth_pkg::IDX_CONTROL, 16'h0000);
        @(negedge clk);
        cts_n = 1'b1;
        repeat (8) @(negedge clk);
        flags(16'h0460, "cts released");
        $display("test cts done");
        report_and_stop();
    end
endmodule

`default_nettype wire
